// ---- drc_far_side_model.sv ----
`default_nettype none
module drc_far_side_model (
   // Clock
   input  wire logic        clk_i,
   // Rms estimate stream out
   output var  logic        rms_valid_o,
   output var  logic [31:0] rms_o,
   // Coefficient stream in
   input  wire logic        coef_valid_i,
   input  wire logic [27:0] coef_i
);
   timeunit 1ns;
   timeprecision 1ps;

   logic        req = 1'b0;
   logic [31:0] req_v = '0;
   int          cyc_cnt = 0;
   int          taken[$];
   logic [27:0] got[$];
   int          lat[$];

   initial begin
      rms_valid_o = 1'b0;
      rms_o = '0;
   end

   ////////////////////////////////////////////////////////////////////
   // Idle data lines toggle so a stale sample can never look valid
   always @(posedge clk_i) begin
      cyc_cnt++;
      if (rms_valid_o) taken.push_back(cyc_cnt);
      if (coef_valid_i === 1'b1) begin
         got.push_back(coef_i);
         lat.push_back(cyc_cnt - taken.pop_front());
      end
      rms_valid_o <= req;
      rms_o <= req ? req_v : ~rms_o;
   end

   // Requests change on the falling edge, sampled on the rising one
   task automatic send(input logic [31:0] v);
      @(negedge clk_i);
      req = 1'b1;
      req_v = v;
   endtask

   task automatic idle();
      @(negedge clk_i);
      req = 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- drc_gain_coefficient_engine.sv ----
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
`default_nettype none
module drc_gain_coefficient_engine (
   // Clock and reset
   input  wire logic                              clk_i,
   input  wire logic                              rst_i,
   // Wishbone slave
   input  wire logic                              cyc_i,
   input  wire logic                              stb_i,
   input  wire logic                              we_i,
   input  wire logic [5:0]                        adr_i,
   input  wire logic [3:0]                        sel_i,
   input  wire logic [31:0]                       dat_i,
   output logic [31:0]                            dat_o,
   output logic                                   ack_o,
   // Rms estimate stream
   input  wire logic                              rms_valid_i,
   input  wire logic [drc_gain_pkg::RMS_W-1:0]    rms_i,
   // Gain coefficient stream
   output logic                                   coef_valid_o,
   output logic [drc_gain_pkg::COEF_W-1:0]        coef_o
);
   import drc_gain_pkg::*;

   param_type                cfg, next_cfg;
   logic [SLOPE_W-1:0]       mix_gain, next_mix_gain;
   logic [31:0]              next_dat, cur, wr;
   logic                     next_ack;
   region_type               region_last, next_region_last;
   logic [15:0]              coef_count, next_coef_count;

   logic                     valid_a, next_valid_a;
   logic [WORD_W-1:0]        word_a, next_word_a;
   param_type                p_a, next_p_a, p_b;
   logic [PROD_IN_W-1:0]     prod_in;
   logic                     valid_b;
   logic [WORD_W-1:0]        level_b;
   logic                     valid_c, next_valid_c;
   region_type               region_c, next_region_c;
   logic [WORD_W-1:0]        ofs_c, next_ofs_c;
   logic signed [GAIN_W-1:0] prod_c, next_prod_c;
   logic                     en_c, next_en_c;
   logic [WORD_W-1:0]        thr_sel;
   logic [SLOPE_W-1:0]       k_sel;
   logic signed [DIFF_W-1:0] diff;
   logic signed [GAIN_W-1:0] gain;
   logic signed [53:0]       ip;
   logic signed [53:0]       nip;
   logic [COEF_W-1:0]        mant, next_coef;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = d[8*b +: 8];
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Register file, one wait state on every access
   always_comb begin
      next_cfg = cfg;
      next_mix_gain = mix_gain;
      next_ack = cyc_i & stb_i & ~ack_o;
      case (adr_i[5:2])
         ADDR_CTRL:       cur = {31'h0, cfg.enable};
         ADDR_MIX_GAIN:   cur = {4'h0, mix_gain};
         ADDR_LOW_THR_L:  cur = cfg.low_threshold[31:0];
         ADDR_LOW_THR_H:  cur = {16'h0, cfg.low_threshold[47:32]};
         ADDR_HIGH_THR_L: cur = cfg.high_threshold[31:0];
         ADDR_HIGH_THR_H: cur = {16'h0, cfg.high_threshold[47:32]};
         ADDR_LOW_OFS_L:  cur = cfg.low_offset[31:0];
         ADDR_LOW_OFS_H:  cur = {16'h0, cfg.low_offset[47:32]};
         ADDR_HIGH_OFS_L: cur = cfg.high_offset[31:0];
         ADDR_HIGH_OFS_H: cur = {16'h0, cfg.high_offset[47:32]};
         ADDR_LOW_SLOPE:  cur = {4'h0, cfg.low_region_slope};
         ADDR_MID_SLOPE:  cur = {4'h0, cfg.mid_region_slope};
         ADDR_HIGH_SLOPE: cur = {4'h0, cfg.high_region_slope};
         ADDR_STATUS:     cur = {coef_count, 13'h0, region_last};
         ADDR_LAST_COEF:  cur = {4'h0, coef_o};
         default:         cur = '0;
      endcase
      wr = merge(cur, dat_i, sel_i);
      next_dat = (next_ack && !we_i) ? cur : '0;
      if (next_ack && we_i) begin
         case (adr_i[5:2])
            ADDR_CTRL:       next_cfg.enable = wr[CTRL_EN_BIT];
            ADDR_MIX_GAIN:   next_mix_gain = wr[SLOPE_W-1:0];
            ADDR_LOW_THR_L:  next_cfg.low_threshold[31:0] = wr;
            ADDR_LOW_THR_H:  next_cfg.low_threshold[47:32] = wr[15:0];
            ADDR_HIGH_THR_L: next_cfg.high_threshold[31:0] = wr;
            ADDR_HIGH_THR_H: next_cfg.high_threshold[47:32] = wr[15:0];
            ADDR_LOW_OFS_L:  next_cfg.low_offset[31:0] = wr;
            ADDR_LOW_OFS_H:  next_cfg.low_offset[47:32] = wr[15:0];
            ADDR_HIGH_OFS_L: next_cfg.high_offset[31:0] = wr;
            ADDR_HIGH_OFS_H: next_cfg.high_offset[47:32] = wr[15:0];
            ADDR_LOW_SLOPE:  next_cfg.low_region_slope = wr[SLOPE_W-1:0];
            ADDR_MID_SLOPE:  next_cfg.mid_region_slope = wr[SLOPE_W-1:0];
            ADDR_HIGH_SLOPE: next_cfg.high_region_slope = wr[SLOPE_W-1:0];
            default:         next_cfg = cfg;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg.enable            <= 1'b1;
         cfg.low_threshold     <= RST_LOW_THR;
         cfg.high_threshold    <= RST_HIGH_THR;
         cfg.low_offset        <= RST_OFFSET;
         cfg.high_offset       <= RST_OFFSET;
         cfg.low_region_slope  <= RST_SLOPE;
         cfg.mid_region_slope  <= RST_SLOPE;
         cfg.high_region_slope <= RST_SLOPE;
         mix_gain              <= RST_MIX_GAIN;
         ack_o                 <= 1'b0;
         dat_o                 <= '0;
      end else begin
         cfg      <= next_cfg;
         mix_gain <= next_mix_gain;
         ack_o    <= next_ack;
         dat_o    <= next_dat;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Stage A: input mixer and parameter snapshot
   always_comb begin
      prod_in = PROD_IN_W'(rms_i) * PROD_IN_W'(mix_gain);
      // Saturate rather than wrap when the mixer boosts past full scale
      if (|prod_in[PROD_IN_W-1:MIX_MSB+1]) begin
         next_word_a = '1;
      end else begin
         next_word_a = prod_in[MIX_MSB:MIX_LSB];
      end
      next_valid_a = rms_valid_i;
      next_p_a = rms_valid_i ? cfg : p_a;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         valid_a <= 1'b0;
         word_a  <= '0;
         p_a     <= '0;
      end else begin
         valid_a <= next_valid_a;
         word_a  <= next_word_a;
         p_a     <= next_p_a;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Stage B: log conversion
   drc_log_converter u_log (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .valid_i (valid_a),
      .word_i  (word_a),
      .valid_o (valid_b),
      .level_o (level_b)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         p_b <= '0;
      end else begin
         p_b <= p_a;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Stage C: region choice and slope product
   always_comb begin
      // Level counts down from full scale, so louder means smaller
      if ($signed(level_b) < $signed(p_b.high_threshold)) begin
         next_region_c = REG_HIGH;
         thr_sel = p_b.high_threshold;
         k_sel = p_b.high_region_slope;
         next_ofs_c = p_b.high_offset;
      end else if ($signed(level_b) < $signed(p_b.low_threshold)) begin
         next_region_c = REG_MID;
         thr_sel = p_b.high_threshold;
         k_sel = p_b.mid_region_slope;
         next_ofs_c = p_b.high_offset;
      end else begin
         next_region_c = REG_LOW;
         thr_sel = p_b.low_threshold;
         k_sel = p_b.low_region_slope;
         next_ofs_c = p_b.low_offset;
      end
      diff = $signed(DIFF_W'(thr_sel)) - $signed(DIFF_W'(level_b));
      next_prod_c = GAIN_W'(diff) * GAIN_W'($signed(k_sel));
      next_valid_c = valid_b;
      next_en_c = p_b.enable;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         valid_c  <= 1'b0;
         region_c <= REG_LOW;
         ofs_c    <= '0;
         prod_c   <= '0;
         en_c     <= 1'b0;
      end else begin
         valid_c  <= next_valid_c;
         region_c <= next_region_c;
         ofs_c    <= next_ofs_c;
         prod_c   <= next_prod_c;
         en_c     <= next_en_c;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Stage D: log gain and antilog; mantissa is linear in the fraction
   always_comb begin
      gain = GAIN_W'(LOG_BIAS) - GAIN_W'($signed(ofs_c))
             + (prod_c >>> FRAC_W);
      ip = gain[GAIN_W-1:FRAC_W];
      nip = -ip;
      mant = {4'h0, 1'b1, gain[FRAC_W-1:0]};
      if (!en_c) begin
         next_coef = COEF_UNITY;
      end else if (ip > EXP_INT_MAX) begin
         next_coef = COEF_MAX;
      end else if (ip < EXP_INT_MIN) begin
         next_coef = '0;
      end else if (ip >= 0) begin
         next_coef = mant << ip[1:0];
      end else begin
         next_coef = mant >> nip[4:0];
      end
      next_region_last = valid_c ? region_c : region_last;
      next_coef_count = coef_count + 16'(valid_c);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         coef_valid_o <= 1'b0;
         coef_o       <= COEF_UNITY;
         region_last  <= REG_LOW;
         coef_count   <= '0;
      end else begin
         coef_valid_o <= valid_c;
         coef_o       <= valid_c ? next_coef : coef_o;
         region_last  <= next_region_last;
         coef_count   <= next_coef_count;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   property p_latency;
      @(posedge clk_i) disable iff (rst_i)
      rms_valid_i |-> ##4 coef_valid_o;
   endproperty
   a_latency: assert property (p_latency)
      else $error("coefficient missing four cycles after sample");
   property p_no_spurious;
      @(posedge clk_i) disable iff (rst_i)
      coef_valid_o |-> $past(rms_valid_i, 4);
   endproperty
   a_no_spurious: assert property (p_no_spurious)
      else $error("coefficient without a sample");
   property p_snapshot;
      @(posedge clk_i) disable iff (rst_i)
      rms_valid_i |=> p_a == $past(cfg) ##1 p_b == $past(cfg, 2);
   endproperty
   a_snapshot: assert property (p_snapshot)
      else $error("parameters not captured with sample");
   property p_high_region;
      @(posedge clk_i) disable iff (rst_i)
      valid_b && $signed(level_b) < $signed(p_b.high_threshold)
      |=> region_c == REG_HIGH && ofs_c == $past(p_b.high_offset);
   endproperty
   a_high_region: assert property (p_high_region)
      else $error("high region not chosen");
   property p_mid_region;
      @(posedge clk_i) disable iff (rst_i)
      valid_b && $signed(level_b) >= $signed(p_b.high_threshold)
      && $signed(level_b) < $signed(p_b.low_threshold)
      |=> region_c == REG_MID && ofs_c == $past(p_b.high_offset);
   endproperty
   a_mid_region: assert property (p_mid_region)
      else $error("mid region not chosen");
   property p_low_region;
      @(posedge clk_i) disable iff (rst_i)
      valid_b && $signed(level_b) >= $signed(p_b.high_threshold)
      && $signed(level_b) >= $signed(p_b.low_threshold)
      |=> region_c == REG_LOW && ofs_c == $past(p_b.low_offset);
   endproperty
   a_low_region: assert property (p_low_region)
      else $error("low region not snapped to low offset");
   property p_unity;
      @(posedge clk_i) disable iff (rst_i)
      valid_c && en_c && prod_c == '0 && ofs_c == WORD_W'(LOG_BIAS)
      |=> coef_valid_o && coef_o == COEF_UNITY;
   endproperty
   a_unity: assert property (p_unity)
      else $error("zero offset at threshold is not unity");
   property p_bypass;
      @(posedge clk_i) disable iff (rst_i)
      valid_c && !en_c |=> coef_o == COEF_UNITY;
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("disabled engine must pass unity");
   property p_ack;
      @(posedge clk_i) disable iff (rst_i)
      cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("bus ack not one cycle");
   c_high: cover property (@(posedge clk_i) valid_c && region_c == REG_HIGH);
   c_mid: cover property (@(posedge clk_i) valid_c && region_c == REG_MID);
   c_low: cover property (@(posedge clk_i) valid_c && region_c == REG_LOW);
   // Falling-output region, reached through the low slope
   c_neg_slope: cover property (@(posedge clk_i) disable iff (rst_i)
      valid_b && $signed(p_b.low_region_slope) < -28'sh080_0000);
endmodule
`default_nettype wire

// ---- drc_gain_coefficient_engine_test.sv ----
`default_nettype none
`define CHECK(a, b) begin \
   num_checks++; \
   if ((a) !== (b)) begin \
      num_errors++; \
      $display("Error at %0t: got %h expected %h", $time, a, b); \
   end \
end
module drc_gain_coefficient_engine_test;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i  = 1'b0;
   logic [5:0]  adr_i = '0;
   logic [3:0]  sel_i = '0;
   logic [31:0] dat_i = '0;
   wire  [31:0] dat_o;
   wire         ack_o;
   wire         rms_valid;
   wire  [31:0] rms;
   wire         coef_valid;
   wire  [27:0] coef;
   int          num_errors = 0;
   int          num_checks = 0;
   logic [31:0] rd;
   logic [31:0] rst_tab[16] = '{32'h1, 32'h0080_0000, 32'h0400_0000,
      32'h0, 32'h0200_0000, 32'h0, 32'h0200_0000, 32'h0, 32'h0200_0000,
      32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'h0080_0000, 32'h0};
   logic [31:0] rms_tab[5] = '{32'h8000_0000, 32'h0200_0000,
      32'h0080_0000, 32'h0040_0000, 32'h0020_0000};

   always #2.5 clk_i = ~clk_i;

   drc_gain_coefficient_engine drc_gain_coefficient_engine_inst (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .rms_valid_i(rms_valid),
      .rms_i(rms), .coef_valid_o(coef_valid), .coef_o(coef));

   drc_far_side_model drc_far_side_model_inst (
      .clk_i(clk_i), .rms_valid_o(rms_valid), .rms_o(rms),
      .coef_valid_i(coef_valid), .coef_i(coef));

   ////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("TB: %0d checks, %0d errors", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Request held until ack is sampled high at a rising edge
   task automatic wb(input logic [5:0] a, input logic w,
                     input logic [3:0] s, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      sel_i <= s;
      dat_i <= d;
      for (n = 0; n < 20; n++) begin
         @(posedge clk_i);
         if (ack_o === 1'b1) break;
      end
      if (n == 20) begin
         num_errors++;
         test_done();
      end
      // Same edge as ack: take read data, then release
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      wb(a, 1'b1, 4'hf, d);
   endtask

   task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
      wb(a, 1'b0, 4'hf, 32'h0);
      `CHECK(rd, e)
   endtask

   // Every coefficient must arrive exactly four cycles after its sample
   task automatic coef_chk(input logic [27:0] e);
      int          n;
      int          l;
      logic [27:0] c;
      for (n = 0; n < 20 && drc_far_side_model_inst.got.size() == 0; n++)
         @(posedge clk_i);
      if (n == 20) begin
         num_errors++;
         test_done();
      end
      c = drc_far_side_model_inst.got.pop_front();
      l = drc_far_side_model_inst.lat.pop_front();
      `CHECK(c, e)
      `CHECK(l, 4)
   endtask

   task automatic one(input logic [31:0] v, input logic [27:0] e);
      drc_far_side_model_inst.send(v);
      drc_far_side_model_inst.idle();
      coef_chk(e);
   endtask

   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 16; i++) rd_chk(6'(i * 4), rst_tab[i]);
      wr(6'h0c, 32'hffff_0000);
      rd_chk(6'h0c, 32'h0);
      wb(6'h04, 1'b1, 4'h1, 32'h0000_00aa);
      rd_chk(6'h04, 32'h0080_00aa);
      wr(6'h04, 32'h0080_0000);
      $display("TB: register test done");
      wr(6'h20, 32'h0180_0000);
      one(32'h0800_0000, 28'h100_0000);
      wr(6'h20, 32'h0200_0000);
      one(32'h0800_0000, 28'h080_0000);
      $display("TB: pivot test done");
      wr(6'h30, 32'h0fc0_0000);
      wr(6'h2c, 32'h0040_0000);
      wr(6'h28, 32'h0f40_0000);
      wr(6'h18, 32'h0100_0000);
      // Back to back, so ordering and per-sample pairing are exercised
      for (int i = 0; i < 5; i++) drc_far_side_model_inst.send(rms_tab[i]);
      drc_far_side_model_inst.idle();
      coef_chk(28'h020_0000);
      coef_chk(28'h040_0000);
      coef_chk(28'h200_0000);
      coef_chk(28'h600_0000);
      coef_chk(28'h7ff_ffff);
      wr(6'h10, 32'h0280_0000);
      one(32'h0800_0000, 28'h060_0000);
      wr(6'h34, 32'hffff_ffff);
      rd_chk(6'h34, 32'h0008_0004);
      rd_chk(6'h38, 32'h0060_0000);
      $display("TB: region test done");
      wr(6'h04, 32'h0100_0000);
      one(32'h0100_0000, 28'h060_0000);
      wr(6'h00, 32'h0);
      one(32'h8000_0000, 28'h080_0000);
      $display("TB: mixer and enable test done");
      test_done();
   end

   // Watchdog for a hung run
   initial begin
      repeat (20000) @(posedge clk_i);
      num_errors++;
      test_done();
   end
endmodule
`default_nettype wire

// ---- drc_gain_pkg.sv ----
`default_nettype none
package drc_gain_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Widths and fixed-point layout
   localparam int unsigned RMS_W     = 32;
   localparam int unsigned WORD_W    = 48;
   localparam int unsigned SLOPE_W   = 28;
   localparam int unsigned COEF_W    = 28;
   localparam int unsigned FRAC_W    = 23;
   localparam int unsigned PROD_IN_W = 60;
   localparam int unsigned MIX_LSB   = 7;
   localparam int unsigned MIX_MSB   = 54;
   localparam int unsigned DIFF_W    = 49;
   localparam int unsigned GAIN_W    = 77;

   ////////////////////////////////////////////////////////////////////////
   // Register word indices (byte address is four times the index)
   localparam logic [3:0] ADDR_CTRL       = 4'h0;
   localparam logic [3:0] ADDR_MIX_GAIN   = 4'h1;
   localparam logic [3:0] ADDR_LOW_THR_L  = 4'h2;
   localparam logic [3:0] ADDR_LOW_THR_H  = 4'h3;
   localparam logic [3:0] ADDR_HIGH_THR_L = 4'h4;
   localparam logic [3:0] ADDR_HIGH_THR_H = 4'h5;
   localparam logic [3:0] ADDR_LOW_OFS_L  = 4'h6;
   localparam logic [3:0] ADDR_LOW_OFS_H  = 4'h7;
   localparam logic [3:0] ADDR_HIGH_OFS_L = 4'h8;
   localparam logic [3:0] ADDR_HIGH_OFS_H = 4'h9;
   localparam logic [3:0] ADDR_LOW_SLOPE  = 4'ha;
   localparam logic [3:0] ADDR_MID_SLOPE  = 4'hb;
   localparam logic [3:0] ADDR_HIGH_SLOPE = 4'hc;
   localparam logic [3:0] ADDR_STATUS     = 4'hd;
   localparam logic [3:0] ADDR_LAST_COEF  = 4'he;
   localparam int unsigned CTRL_EN_BIT    = 0;
   localparam int unsigned STAT_CNT_LSB   = 16;

   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [47:0] RST_LOW_THR   = 48'h0000_0400_0000;
   localparam logic [47:0] RST_HIGH_THR  = 48'h0000_0200_0000;
   localparam logic [47:0] RST_OFFSET    = 48'h0000_0200_0000;
   localparam logic [27:0] RST_SLOPE     = 28'h000_0000;
   localparam logic [27:0] RST_MIX_GAIN  = 28'h080_0000;

   ////////////////////////////////////////////////////////////////////////
   // Arithmetic constants
   localparam logic [27:0] COEF_UNITY    = 28'h080_0000;
   localparam logic [27:0] COEF_MAX      = 28'h7ff_ffff;
   localparam logic signed [47:0] LOG_BIAS = 48'sh0000_0200_0000;
   localparam logic [47:0] LEVEL_SILENT  = 48'h0000_3f80_0000;
   localparam logic [5:0]  FULL_SCALE_BIT = 6'h2f;
   localparam logic signed [53:0] EXP_INT_MAX = 54'sh3;
   localparam logic signed [53:0] EXP_INT_MIN = -54'sh18;

   ////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [2:0] {
      REG_LOW  = 3'b001,
      REG_MID  = 3'b010,
      REG_HIGH = 3'b100
   } region_type;

   typedef struct packed {
      logic        enable;
      logic [47:0] low_threshold;
      logic [47:0] high_threshold;
      logic [47:0] low_offset;
      logic [47:0] high_offset;
      logic [27:0] low_region_slope;
      logic [27:0] mid_region_slope;
      logic [27:0] high_region_slope;
   } param_type;

endpackage
`default_nettype wire

// ---- drc_log_converter.sv ----
`default_nettype none
module drc_log_converter (
   // Clock and reset
   input  wire logic                             clk_i,
   input  wire logic                             rst_i,
   // Linear word in
   input  wire logic                             valid_i,
   input  wire logic [drc_gain_pkg::WORD_W-1:0]  word_i,
   // Attenuation below full scale, 25.23 log2 units
   output logic                                  valid_o,
   output logic [drc_gain_pkg::WORD_W-1:0]       level_o
);
   import drc_gain_pkg::*;

   logic [5:0]              msb;
   logic                    found;
   logic [WORD_W-1:0]       norm;
   logic [FRAC_W-1:0]       frac;
   logic signed [DIFF_W-1:0] att;
   logic [WORD_W-1:0]       next_level;

   ////////////////////////////////////////////////////////////////////////
   // Mitchell log: mantissa taken as the fraction, error under 0.09 units
   always_comb begin
      msb = '0;
      found = 1'b0;
      for (int b = 0; b < WORD_W; b++) begin
         if (word_i[b]) begin
            msb = 6'(b);
            found = 1'b1;
         end
      end
      norm = word_i << (FULL_SCALE_BIT - msb);
      frac = norm[WORD_W-2 -: FRAC_W];
      att = $signed(DIFF_W'(FULL_SCALE_BIT - msb) << FRAC_W)
            - $signed(DIFF_W'(frac));
      if (!found) begin
         next_level = LEVEL_SILENT;
      end else if (att < 0) begin
         // Above full scale after mixing: clamp at 0 dB
         next_level = '0;
      end else begin
         next_level = att[WORD_W-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         valid_o <= 1'b0;
         level_o <= '0;
      end else begin
         valid_o <= valid_i;
         level_o <= next_level;
      end
   end

endmodule
`default_nettype wire
